// [design/evle_pkg.sv]
// Purpose: Shared constants and types for the code-store verify, lock and encryption path
// Assumes: 125 MHz system clock; programming oscillator at its slowest, 4 MHz
// Notes:   Times are kept in their printed units; cycle counts derive from them
package evle_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_BYTES = 16384;
  localparam int unsigned ENC_BYTES = 64;
  localparam int unsigned ENC_SEL_W = 6;
  localparam int unsigned LOCK_BITS = 3;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
  localparam logic [LOCK_BITS-1:0] ERASED_LOCKS = 3'h7;

  // ------------------------------------------------------------
  // Signature locations
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SIG_ADDR0 = 14'h0030;
  localparam logic [ADDR_W-1:0] SIG_ADDR1 = 14'h0031;
  localparam logic [ADDR_W-1:0] SIG_ADDR2 = 14'h0060;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned OSC_PERIOD_NS = 250;
  localparam int unsigned SETUP_OSC_PERIODS = 48;
  localparam int unsigned SETUP_NS = SETUP_OSC_PERIODS * OSC_PERIOD_NS;
  // Least time, rounded up
  localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest time, rounded down
  localparam int unsigned ACCESS_CYC = SETUP_NS / CLK_PERIOD_NS;
  localparam int unsigned VPP_SETUP_US = 10;
  localparam int unsigned VPP_CYC = (VPP_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_US = 10;
  localparam int unsigned GAP_CYC = (GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_MIN_US = 90;
  localparam int unsigned PULSE_MAX_US = 110;
  localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PULSE_MAX_CYC = (PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CODE_PULSES = 5;
  localparam int unsigned ARRAY_PULSES = 25;
  localparam int unsigned TIMER_W = 16;
  localparam int unsigned PULSE_CNT_W = 5;

  // ------------------------------------------------------------
  // Control combinations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_CODE_PROGRAM_STROBE,
    MODE_CODE_VERIFY,
    MODE_ENC_PROGRAM_STROBE,
    MODE_LOCK1_PROGRAM_STROBE,
    MODE_LOCK2_PROGRAM_STROBE,
    MODE_LOCK3_PROGRAM_STROBE,
    MODE_SIG_READ
  } evle_mode_t;

endpackage

// [design/evle_if.sv]
// Purpose: Programming link between external programmer and the device
// Assumes: Data lines split into per-party value and enable; no shared wire is resolved, the monitor flags both ends driving
// Notes:   Strobe and enable are active low, as on the pins
`timescale 1ns/100ps
`default_nettype none
interface evle_if import evle_pkg::*;;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic wr_data_oe;
  logic [DATA_W-1:0] rd_data;
  logic rd_data_oe;
  evle_mode_t mode;
  logic program_strobe_n;
  logic vpp_on;
  logic enable_n;

  modport dev (
    input addr, wr_data, wr_data_oe, mode, program_strobe_n, vpp_on, enable_n,
    output rd_data, rd_data_oe
  );

  modport host (
    output addr, wr_data, wr_data_oe, mode, program_strobe_n, vpp_on, enable_n,
    input rd_data, rd_data_oe
  );
endinterface // evle_if
`default_nettype wire

// [design/evle_timer.sv]
// Purpose: Down counter that reports the end of a loaded wait as a one-cycle pulse
// Assumes: A new start only after the previous done
// Notes:   Wait spans count_i cycles from the edge that takes start_i
`timescale 1ns/100ps
`default_nettype none
module evle_timer import evle_pkg::*; #(
  parameter int unsigned W = TIMER_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [W-1:0] count_i,
  output logic done_o
);
  logic [W-1:0] cnt;
  logic busy;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      busy <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt <= count_i;
        busy <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 1'b1;
        if (cnt <= W'(1)) begin
          busy <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule // evle_timer
`default_nettype wire

// [design/evle_device.sv]
// Purpose: Device end: code store, encryption array, lock bits and verify path
// Assumes: Link inputs synchronous to CLOCK_I; ERASE_I issued before code is trusted
// Notes:   Programming writes on the strobe's rising edge and only clears bits
`timescale 1ns/100ps
`default_nettype none
module evle_device import evle_pkg::*; #(
  // Identification values are arbitrary
  parameter logic [DATA_W-1:0] SIG_BYTE0 = 8'hA1,
  parameter logic [DATA_W-1:0] SIG_BYTE1 = 8'hB2,
  parameter logic [DATA_W-1:0] SIG_BYTE2 = 8'hC3,
  parameter bit MASK_VARIANT = 1'b0
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic ERASE_I,
  input wire logic CPU_RESET_I,
  input wire logic EXTERNAL_ACCESS_PIN_I,
  evle_if.dev link,
  output logic ERASE_BUSY_O,
  output logic PROGRAM_STROBE_REFUSED_O,
  output logic CODE_TABLE_MOVE_BLOCK_O,
  output logic EXT_EXEC_BLOCK_O,
  output logic EXTERNAL_ACCESS_O
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [DATA_W-1:0] code_mem [CODE_BYTES];
  logic [DATA_W-1:0] enc_mem [ENC_BYTES];
  // A set bit is an erased, unprogrammed cell
  logic [LOCK_BITS-1:0] lock_bits;
  logic erase_busy;
  logic [ADDR_W-1:0] erase_addr;
  logic strobe_n_q;
  logic ea_latched;
  logic rd_data_oe;
  logic [DATA_W-1:0] rd_data;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic lock_level_one_bit;
  logic lock_level_two_bit;
  logic lock_level_three_bit;
  logic level1;
  logic level2;
  logic level3;
  logic enc_on;
  logic program_strobe_edge;
  logic [ENC_SEL_W-1:0] enc_sel;
  logic [DATA_W-1:0] code_byte;
  logic [DATA_W-1:0] enc_byte;
  logic [DATA_W-1:0] sig_byte;

  assign lock_level_one_bit = ~lock_bits[0];
  assign lock_level_two_bit = ~lock_bits[1];
  assign lock_level_three_bit = ~lock_bits[2];

  // A higher bit counts only on top of the lower ones, so stray
  // combinations fall back to the highest complete level.
  assign level1 = lock_level_one_bit;
  assign level2 = level1 & lock_level_two_bit;
  assign level3 = level2 & lock_level_three_bit;

  // Mask variant never encrypts without its single lock
  assign enc_on = MASK_VARIANT ? level1 : 1'b1;

  assign enc_sel = link.addr[ENC_SEL_W-1:0];
  assign code_byte = code_mem[link.addr];
  assign enc_byte = enc_mem[enc_sel];

  // Programming happens on the strobe's rising edge with Vpp raised and
  // the programmer driving data, so a floating bus never clears cells.
  assign program_strobe_edge = ~strobe_n_q & link.program_strobe_n & link.vpp_on & link.wr_data_oe & ~erase_busy;

  always_comb begin
    sig_byte = ERASED_BYTE;
    if (link.addr == SIG_ADDR0) begin
      sig_byte = SIG_BYTE0;
    end else if (link.addr == SIG_ADDR1) begin
      sig_byte = SIG_BYTE1;
    end else if (link.addr == SIG_ADDR2) begin
      sig_byte = SIG_BYTE2;
    end
  end

  // ------------------------------------------------------------
  // Strobe edge tracking
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      strobe_n_q <= 1'b1;
    end else if (CE_I) begin
      strobe_n_q <= link.program_strobe_n;
    end
  end

  // ------------------------------------------------------------
  // Erase sweep
  // ------------------------------------------------------------
  // Sweeping one byte a cycle keeps the store a plain RAM at the
  // cost of a 16K-cycle busy window.
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      erase_busy <= 1'b0;
      erase_addr <= '0;
    end else if (CE_I) begin
      if (!erase_busy && ERASE_I) begin
        erase_busy <= 1'b1;
        erase_addr <= '0;
      end else if (erase_busy) begin
        erase_addr <= erase_addr + 1'b1;
        if (erase_addr == ADDR_W'(CODE_BYTES - 1)) begin
          erase_busy <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Code store
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (CE_I) begin
      if (erase_busy) begin
        code_mem[erase_addr] <= ERASED_BYTE;
      end else if (program_strobe_edge && link.mode == MODE_CODE_PROGRAM_STROBE && !level1) begin
        code_mem[link.addr] <= code_byte & link.wr_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Encryption array
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < ENC_BYTES; i++) begin
        enc_mem[i] <= ERASED_BYTE;
      end
    end else if (CE_I) begin
      if (!erase_busy && ERASE_I) begin
        for (int i = 0; i < ENC_BYTES; i++) begin
          enc_mem[i] <= ERASED_BYTE;
        end
      end else if (program_strobe_edge && link.mode == MODE_ENC_PROGRAM_STROBE && !level1) begin
        enc_mem[enc_sel] <= enc_byte & link.wr_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Lock bits
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lock_bits <= ERASED_LOCKS;
    end else if (CE_I) begin
      if (!erase_busy && ERASE_I) begin
        lock_bits <= ERASED_LOCKS;
      end else if (program_strobe_edge) begin
        unique case (link.mode)
          MODE_LOCK1_PROGRAM_STROBE: lock_bits[0] <= 1'b0;
          MODE_LOCK2_PROGRAM_STROBE: lock_bits[1] <= MASK_VARIANT;
          MODE_LOCK3_PROGRAM_STROBE: lock_bits[2] <= MASK_VARIANT;
          default: lock_bits <= lock_bits;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PROGRAM_STROBE_REFUSED_O <= 1'b0;
    end else if (CE_I) begin
      PROGRAM_STROBE_REFUSED_O <= program_strobe_edge & level1 &
        (link.mode == MODE_CODE_PROGRAM_STROBE || link.mode == MODE_ENC_PROGRAM_STROBE);
    end
  end

  // ------------------------------------------------------------
  // Verify and signature read
  // ------------------------------------------------------------
  // One registered stage: data follows address or enable by a
  // single cycle, far inside the access limit.
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_data <= ERASED_BYTE;
      rd_data_oe <= 1'b0;
    end else if (CE_I) begin
      rd_data_oe <= 1'b0;
      if (!link.enable_n && !erase_busy) begin
        if (link.mode == MODE_SIG_READ) begin
          rd_data <= sig_byte;
          rd_data_oe <= 1'b1;
        end else if (link.mode == MODE_CODE_VERIFY && !level2) begin
          rd_data <= enc_on ? ~(enc_byte ^ code_byte) : code_byte;
          rd_data_oe <= 1'b1;
        end
      end
    end
  end

  assign link.rd_data = rd_data;
  assign link.rd_data_oe = rd_data_oe;

  // ------------------------------------------------------------
  // Protection outputs
  // ------------------------------------------------------------
  // Locks show only as their effects; no path returns the bits.
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ea_latched <= 1'b0;
    end else if (CE_I && CPU_RESET_I) begin
      ea_latched <= EXTERNAL_ACCESS_PIN_I;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CODE_TABLE_MOVE_BLOCK_O <= 1'b0;
      EXT_EXEC_BLOCK_O <= 1'b0;
      EXTERNAL_ACCESS_O <= 1'b0;
      ERASE_BUSY_O <= 1'b0;
    end else if (CE_I) begin
      CODE_TABLE_MOVE_BLOCK_O <= level1;
      EXT_EXEC_BLOCK_O <= level3;
      EXTERNAL_ACCESS_O <= level1 ? ea_latched : EXTERNAL_ACCESS_PIN_I;
      ERASE_BUSY_O <= erase_busy | (ERASE_I & ~erase_busy);
    end
  end

endmodule // evle_device
`default_nettype wire

// [design/evle_host.sv]
// Purpose: Programmer end: sequences program and verify cycles on the link
// Assumes: One command at a time, taken while CMD_READY_O is high
// Notes:   Pulse width is a parameter so simulation can shorten it
`timescale 1ns/100ps
`default_nettype none
module evle_host import evle_pkg::*; #(
  parameter int unsigned PULSE_CYC = PULSE_MIN_CYC
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic CMD_VALID_I,
  input wire evle_mode_t CMD_OP_I,
  input wire logic [ADDR_W-1:0] CMD_ADDR_I,
  input wire logic [DATA_W-1:0] CMD_DATA_I,
  output logic CMD_READY_O,
  output logic RESULT_VALID_O,
  output logic [DATA_W-1:0] RESULT_DATA_O,
  output logic RESULT_DRIVEN_O,
  evle_if.host link
);
  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_VPP, H_PULSE, H_GAP, H_HOLD, H_READ, H_FLOAT
  } evle_hstate_t;

  evle_hstate_t state;
  logic tstart;
  logic tdone;
  logic [TIMER_W-1:0] tload;
  logic [PULSE_CNT_W-1:0] pulses;

  evle_timer #(.W(TIMER_W)) u_timer (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .start_i(tstart),
    .count_i(tload),
    .done_o(tdone)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= H_IDLE;
      tstart <= 1'b0;
      tload <= '0;
      pulses <= '0;
      CMD_READY_O <= 1'b0;
      RESULT_VALID_O <= 1'b0;
      RESULT_DATA_O <= '0;
      RESULT_DRIVEN_O <= 1'b0;
      link.addr <= '0;
      link.wr_data <= '0;
      link.wr_data_oe <= 1'b0;
      link.mode <= MODE_IDLE;
      link.program_strobe_n <= 1'b1;
      link.vpp_on <= 1'b0;
      link.enable_n <= 1'b1;
    end else if (CE_I) begin
      tstart <= 1'b0;
      RESULT_VALID_O <= 1'b0;
      unique case (state)
        H_IDLE: begin
          CMD_READY_O <= 1'b1;
          if (CMD_READY_O && CMD_VALID_I && CMD_OP_I != MODE_IDLE) begin
            CMD_READY_O <= 1'b0;
            link.addr <= CMD_ADDR_I;
            link.mode <= CMD_OP_I;
            tstart <= 1'b1;
            if (CMD_OP_I == MODE_CODE_VERIFY || CMD_OP_I == MODE_SIG_READ) begin
              link.enable_n <= 1'b0;
              tload <= TIMER_W'(ACCESS_CYC);
              state <= H_READ;
            end else begin
              // Fill values are the caller's; unused bytes should vary
              link.wr_data <= CMD_DATA_I;
              link.wr_data_oe <= 1'b1;
              tload <= TIMER_W'(SETUP_CYC);
              pulses <= (CMD_OP_I == MODE_CODE_PROGRAM_STROBE) ? PULSE_CNT_W'(CODE_PULSES)
                                                     : PULSE_CNT_W'(ARRAY_PULSES);
              state <= H_SETUP;
            end
          end
        end
        H_SETUP: if (tdone) begin
          link.vpp_on <= 1'b1;
          tload <= TIMER_W'(VPP_CYC);
          tstart <= 1'b1;
          state <= H_VPP;
        end
        H_VPP, H_GAP: if (tdone) begin
          tstart <= 1'b1;
          if (pulses != '0) begin
            link.program_strobe_n <= 1'b0;
            tload <= TIMER_W'(PULSE_CYC);
            pulses <= pulses - 1'b1;
            state <= H_PULSE;
          end else begin
            link.vpp_on <= 1'b0;
            tload <= TIMER_W'(SETUP_CYC);
            state <= H_HOLD;
          end
        end
        H_PULSE: if (tdone) begin
          link.program_strobe_n <= 1'b1;
          tload <= TIMER_W'(GAP_CYC);
          tstart <= 1'b1;
          state <= H_GAP;
        end
        H_HOLD: if (tdone) begin
          link.wr_data_oe <= 1'b0;
          link.mode <= MODE_IDLE;
          RESULT_VALID_O <= 1'b1;
          CMD_READY_O <= 1'b1;
          state <= H_IDLE;
        end
        H_READ: if (tdone) begin
          RESULT_DATA_O <= link.rd_data;
          RESULT_DRIVEN_O <= link.rd_data_oe;
          link.enable_n <= 1'b1;
          tload <= TIMER_W'(SETUP_CYC);
          tstart <= 1'b1;
          state <= H_FLOAT;
        end
        H_FLOAT: if (tdone) begin
          link.mode <= MODE_IDLE;
          RESULT_VALID_O <= 1'b1;
          CMD_READY_O <= 1'b1;
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule // evle_host
`default_nettype wire

// [test/evle_monitor.sv]
// Purpose: Link checker between programmer end and device end
// Assumes: One clock domain; strobe width shortened to PULSE_CYC
// Notes:   Helper counters other than lo_cnt and pls_cnt saturate so long idle spans never wrap
`timescale 1ns/100ps
`default_nettype none
module evle_monitor import evle_pkg::*; #(
  parameter int unsigned PULSE_CYC = 20,
  parameter logic [DATA_W-1:0] SIG0 = 8'hA1,
  parameter logic [DATA_W-1:0] SIG1 = 8'hB2,
  parameter logic [DATA_W-1:0] SIG2 = 8'hC3
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_data_oe,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_data_oe,
  input wire evle_mode_t mode,
  input wire logic program_strobe_n,
  input wire logic vpp_on,
  input wire logic enable_n
);
  logic [15:0] lo_cnt, hi_cnt, vpp_cnt, stab_cnt, rise_cnt;
  logic [4:0] pls_cnt;
  logic [DATA_W-1:0] sig_exp;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  // ------------------------------------------------------------
  // Span counters
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lo_cnt <= 16'h0000;
      hi_cnt <= 16'hFFFF;
      vpp_cnt <= 16'h0000;
      stab_cnt <= 16'h0000;
      rise_cnt <= 16'hFFFF;
      pls_cnt <= 5'h00;
    end else begin
      lo_cnt <= program_strobe_n ? 16'h0000 : lo_cnt + 16'h0001;
      hi_cnt <= !program_strobe_n ? 16'h0000 : hi_cnt + {15'h0000, ~&hi_cnt};
      vpp_cnt <= !vpp_on ? 16'h0000 : vpp_cnt + {15'h0000, ~&vpp_cnt};
      stab_cnt <= ($changed(addr) || $changed(wr_data)) ? 16'h0000 : stab_cnt + {15'h0000, ~&stab_cnt};
      rise_cnt <= $rose(program_strobe_n) ? 16'h0000 : rise_cnt + {15'h0000, ~&rise_cnt};
      pls_cnt <= !vpp_on ? 5'h00 : pls_cnt + {4'h0, $fell(program_strobe_n)};
    end
  end

  // Unlisted signature locations read as erased
  assign sig_exp = (addr == SIG_ADDR0) ? SIG0 : (addr == SIG_ADDR1) ? SIG1 : (addr == SIG_ADDR2) ? SIG2 : 8'hFF;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_sig_start;
    $fell(enable_n) && mode == MODE_SIG_READ;
  endsequence
  sequence s_sig_drive;
    ##[1:2] rd_data_oe;
  endsequence

  a_no_bus_fight: assert property (!(wr_data_oe && rd_data_oe)) else $error("both ends drive data");
  a_float_after_enable: assert property ($rose(enable_n) |-> ##[0:2] !rd_data_oe)
    else $error("data not floated after enable");
  a_drive_in_time: assert property (s_sig_start |-> s_sig_drive) else $error("data not driven in time");
  a_sig_value: assert property (rd_data_oe && mode == MODE_SIG_READ && $stable(addr) |-> rd_data == sig_exp)
    else $error("signature byte wrong");
  a_pulse_width: assert property ($rose(program_strobe_n) |-> lo_cnt >= PULSE_CYC && lo_cnt <= PULSE_CYC + 2)
    else $error("strobe width wrong");
  a_pulse_gap: assert property ($fell(program_strobe_n) |-> hi_cnt >= GAP_CYC) else $error("strobe gap short");
  a_vpp_setup: assert property ($fell(program_strobe_n) |-> vpp_on && vpp_cnt >= VPP_CYC)
    else $error("vpp setup short");
  a_addr_setup: assert property ($fell(program_strobe_n) |-> stab_cnt >= SETUP_CYC)
    else $error("address setup short");
  a_addr_hold: assert property ($changed(addr) || $changed(wr_data) |-> rise_cnt >= SETUP_CYC)
    else $error("address hold short");
  a_pulse_count: assert property ($fell(vpp_on) |->
    pls_cnt == (mode == MODE_CODE_PROGRAM_STROBE ? CODE_PULSES : ARRAY_PULSES)) else $error("pulse count wrong");
endmodule // evle_monitor
`default_nettype wire

// [test/tb_top.sv]
// Purpose: Self-checking bench joining programmer end and device end
// Assumes: Strobe width shortened to PULSE_SIM cycles
// Notes:   Run time is dominated by the two 25-pulse trains
`timescale 1ns/100ps
`default_nettype none
module tb_top import evle_pkg::*;;
  localparam int unsigned PULSE_SIM = 20;
  // Identification values are arbitrary
  localparam logic [7:0] SIG0 = 8'h5A;
  localparam logic [7:0] SIG1 = 8'h6B;
  localparam logic [7:0] SIG2 = 8'h7C;
  logic CLOCK_I, RST_N_I, CE_I, ERASE_I, CPU_RESET_I, EXTERNAL_ACCESS_PIN_I, CMD_VALID_I;
  evle_mode_t CMD_OP_I;
  logic [ADDR_W-1:0] CMD_ADDR_I;
  logic [DATA_W-1:0] CMD_DATA_I, RESULT_DATA_O;
  logic ERASE_BUSY_O, PROGRAM_STROBE_REFUSED_O, CODE_TABLE_MOVE_BLOCK_O, EXT_EXEC_BLOCK_O, EXTERNAL_ACCESS_O;
  logic CMD_READY_O, RESULT_VALID_O, RESULT_DRIVEN_O;
  int fail_count, num_checks, seed, refused_n;
  int enc_m [ENC_BYTES];
  int code_m [int];
  int exp_q [$];

  evle_if link_bus ();
  evle_device #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .MASK_VARIANT(1'b0)) u_evle_device (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .ERASE_I(ERASE_I), .CPU_RESET_I(CPU_RESET_I),
    .EXTERNAL_ACCESS_PIN_I(EXTERNAL_ACCESS_PIN_I), .link(link_bus), .ERASE_BUSY_O(ERASE_BUSY_O),
    .PROGRAM_STROBE_REFUSED_O(PROGRAM_STROBE_REFUSED_O), .CODE_TABLE_MOVE_BLOCK_O(CODE_TABLE_MOVE_BLOCK_O),
    .EXT_EXEC_BLOCK_O(EXT_EXEC_BLOCK_O), .EXTERNAL_ACCESS_O(EXTERNAL_ACCESS_O));
  evle_host #(.PULSE_CYC(PULSE_SIM)) u_evle_host (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .CMD_VALID_I(CMD_VALID_I), .CMD_OP_I(CMD_OP_I),
    .CMD_ADDR_I(CMD_ADDR_I), .CMD_DATA_I(CMD_DATA_I), .CMD_READY_O(CMD_READY_O),
    .RESULT_VALID_O(RESULT_VALID_O), .RESULT_DATA_O(RESULT_DATA_O), .RESULT_DRIVEN_O(RESULT_DRIVEN_O),
    .link(link_bus));
  evle_monitor #(.PULSE_CYC(PULSE_SIM), .SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2)) u_evle_monitor (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .addr(link_bus.addr), .wr_data(link_bus.wr_data),
    .wr_data_oe(link_bus.wr_data_oe), .rd_data(link_bus.rd_data), .rd_data_oe(link_bus.rd_data_oe),
    .mode(link_bus.mode), .program_strobe_n(link_bus.program_strobe_n), .vpp_on(link_bus.vpp_on),
    .enable_n(link_bus.enable_n));

  // ------------------------------------------------------------
  // Model and compare tasks
  // ------------------------------------------------------------
  function automatic int model_verify(input int a);
    int c;
    c = code_m.exists(a) ? code_m[a] : 255;
    return ~(enc_m[a % ENC_BYTES] ^ c) & 255;
  endfunction

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic check_result(input logic exp_drv);
    int exp;
    exp = exp_q.pop_front();
    num_checks++;
    if (RESULT_DATA_O !== exp[7:0] || RESULT_DRIVEN_O !== exp_drv) begin
      fail_count++;
      $display("[FAIL] %0t result %h drv %b, expected %h", $time, RESULT_DATA_O, RESULT_DRIVEN_O, exp[7:0]);
    end
  endtask

  // Ready is high between commands, so one edge is enough to be taken
  task automatic run_cmd(input evle_mode_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge CLOCK_I);
    CMD_VALID_I <= 1'b1;
    CMD_OP_I <= op;
    CMD_ADDR_I <= a;
    CMD_DATA_I <= d;
    @(posedge CLOCK_I);
    CMD_VALID_I <= 1'b0;
    while (RESULT_VALID_O !== 1'b1 && n < 40000) begin
      @(posedge CLOCK_I);
      #1;
      n++;
    end
    check_flag(RESULT_VALID_O, 1'b1);
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    CLOCK_I = 1'b0;
    forever #4 CLOCK_I = ~CLOCK_I;
  end

  initial begin
    repeat (150000) @(posedge CLOCK_I);
    fail_count++;
    conclude();
  end

  // Each refused strobe edge shows as one pulse
  always @(posedge CLOCK_I) begin
    if (PROGRAM_STROBE_REFUSED_O === 1'b1) refused_n++;
  end

  initial begin
    int a;
    int n;
    logic [7:0] cd;
    logic [7:0] ed;
    logic [ADDR_W-1:0] sa [3];
    sa = '{SIG_ADDR0, SIG_ADDR1, SIG_ADDR2};
    seed = 32'hE292B3F9;
    {RST_N_I, ERASE_I, CPU_RESET_I, EXTERNAL_ACCESS_PIN_I, CMD_VALID_I} = 5'h00;
    CE_I = 1'b1;
    CMD_OP_I = MODE_IDLE;
    CMD_ADDR_I = 14'h0000;
    CMD_DATA_I = 8'h00;
    for (int i = 0; i < ENC_BYTES; i++) enc_m[i] = 255;
    repeat (16) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    repeat (2) @(posedge CLOCK_I);
    #1;
    check_flag(CODE_TABLE_MOVE_BLOCK_O, 1'b0);
    check_flag(EXT_EXEC_BLOCK_O, 1'b0);
    @(posedge CLOCK_I);
    EXTERNAL_ACCESS_PIN_I <= 1'b1;
    repeat (2) @(posedge CLOCK_I);
    #1;
    check_flag(EXTERNAL_ACCESS_O, 1'b1);
    @(posedge CLOCK_I);
    ERASE_I <= 1'b1;
    @(posedge CLOCK_I);
    ERASE_I <= 1'b0;
    #1;
    check_flag(ERASE_BUSY_O, 1'b1);
    n = 0;
    while (ERASE_BUSY_O !== 1'b0 && n < 17000) begin
      @(posedge CLOCK_I);
      #1;
      n++;
    end
    check_flag(ERASE_BUSY_O, 1'b0);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(i == 0 ? SIG0 : (i == 1 ? SIG1 : SIG2));
      run_cmd(MODE_SIG_READ, sa[i], 8'h00);
      check_result(1'b1);
    end
    a = $random(seed) & 32'h00001FFF;
    // Never all ones, so verify does not expose the array byte
    cd = 8'($random(seed)) & 8'hFE;
    ed = 8'($random(seed));
    run_cmd(MODE_CODE_PROGRAM_STROBE, a[13:0], cd);
    code_m[a] = cd;
    run_cmd(MODE_ENC_PROGRAM_STROBE, a[13:0], ed);
    enc_m[a % ENC_BYTES] = ed;
    exp_q.push_back(model_verify(a));
    run_cmd(MODE_CODE_VERIFY, a[13:0], 8'h00);
    check_result(1'b1);
    // Erased neighbour one array period away shows the same array byte
    exp_q.push_back(model_verify(a + 64));
    run_cmd(MODE_CODE_VERIFY, a[13:0] + 14'h0040, 8'h00);
    check_result(1'b1);
    run_cmd(MODE_LOCK1_PROGRAM_STROBE, 14'h0000, 8'h00);
    repeat (2) @(posedge CLOCK_I);
    #1;
    check_flag(CODE_TABLE_MOVE_BLOCK_O, 1'b1);
    check_flag(EXT_EXEC_BLOCK_O, 1'b0);
    @(posedge CLOCK_I);
    CPU_RESET_I <= 1'b1;
    repeat (2) @(posedge CLOCK_I);
    CPU_RESET_I <= 1'b0;
    EXTERNAL_ACCESS_PIN_I <= 1'b0;
    repeat (3) @(posedge CLOCK_I);
    #1;
    check_flag(EXTERNAL_ACCESS_O, 1'b1);
    // Level one refuses the write: every pulse flagged, code byte kept
    run_cmd(MODE_CODE_PROGRAM_STROBE, a[13:0], 8'h00);
    check_flag(refused_n == CODE_PULSES, 1'b1);
    exp_q.push_back(model_verify(a));
    run_cmd(MODE_CODE_VERIFY, a[13:0], 8'h00);
    check_result(1'b1);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
